//--- core/relay_pkg.sv
// Shared constants and types for the breaker and recloser input supervision.
package relay_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_LI = 8;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATE = 8'h04;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFF_OPEN_LIMIT = 8'h10;
  localparam logic [7:0] OFF_RESET_LIMIT = 8'h14;
  localparam logic [7:0] OFF_OPEN_COUNT = 8'h18;
  localparam logic [7:0] OFF_SEALED = 8'h1C;
  localparam logic [7:0] OFF_TARGETS = 8'h20;
  localparam logic [7:0] OFF_MAP_BASE = 8'h40;

  localparam int CTRL_MANUAL_TRIP = 0;
  localparam int CTRL_SEAL_CLEAR = 1;
  localparam int CTRL_TARGET_CLEAR = 2;

  localparam int STATE_BRK_LSB = 0;
  localparam int STATE_UNKNOWN = 2;
  localparam int STATE_OPEN_TMR = 3;
  localparam int STATE_RESET_TMR = 4;
  localparam int STATE_LI_LSB = 8;

  localparam int LI_INHIBIT = 0;
  localparam int LI_AUX_NO = 1;
  localparam int LI_AUX_NC = 2;
  localparam int LI_RECL_EN = 3;
  localparam int LI_EARTH_EN = 4;
  localparam int LI_LOCAL = 5;
  localparam int LI_SEAL_RST = 6;
  localparam int LI_TARGET_RST = 7;
  localparam logic [NUM_LI-1:0] LI_DEFAULTS = 8'h18;

  localparam logic [1:0] MAP_DEASSIGNED = 2'h0;
  localparam logic [1:0] MAP_CLOSED = 2'h1;
  localparam logic [1:0] MAP_OPEN = 2'h2;

  localparam int IRQ_BRK_CHANGE = 0;
  localparam int IRQ_UNKNOWN = 1;
  localparam int IRQ_REFUSED = 2;
  localparam int IRQ_OPEN_EXP = 3;
  localparam int IRQ_RESET_EXP = 4;
  localparam int IRQ_SEAL = 5;
  localparam int IRQ_W = 6;

  localparam logic [1:0] BRK_CODE_UNKNOWN = 2'h0;
  localparam logic [1:0] BRK_CODE_CLOSED = 2'h1;
  localparam logic [1:0] BRK_CODE_OPEN = 2'h2;

  localparam logic [31:0] OPEN_LIMIT_RST = 32'h0000_03E8;
  localparam logic [31:0] RESET_LIMIT_RST = 32'h0000_07D0;

  typedef enum logic [1:0] {TMR_IDLE, TMR_RUN, TMR_FROZEN} timer_state_t;
endpackage

//--- core/input_map_if.sv
// Carrier between the register owner and the contact-to-logical-input mapper.
`timescale 1ns/10ps
interface input_map_if #(
  parameter int NUM_PHYS = 8,
  parameter int NUM_LI = 8
);
  logic [NUM_PHYS-1:0] phys;
  logic [NUM_LI-1:0][2*NUM_PHYS-1:0] map;
  logic [NUM_LI-1:0] logical;

  modport mapper (input phys, input map, output logical);
  modport owner (output phys, output map, input logical);
endinterface

//--- core/input_mapper.sv
// Programmable map from physical contacts to logical inputs.
`timescale 1ns/10ps
module input_mapper #(
  parameter int NUM_PHYS = 8,
  parameter int NUM_LI = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input_map_if.mapper bus
);

  // A code outside the three documented ones is treated as deassigned.
  function automatic logic term_active(input logic [1:0] code, input logic level);
    term_active = ((code == relay_pkg::MAP_CLOSED) && level) ||
                  ((code == relay_pkg::MAP_OPEN) && !level);
  endfunction

  function automatic logic term_assigned(input logic [1:0] code);
    term_assigned = (code == relay_pkg::MAP_CLOSED) || (code == relay_pkg::MAP_OPEN);
  endfunction

  logic [NUM_LI-1:0][NUM_PHYS-1:0] hit;
  logic [NUM_LI-1:0][NUM_PHYS-1:0] used;
  logic [NUM_LI-1:0] logical_d;
  logic [NUM_LI-1:0] logical_q;

  for (genvar li = 0; li < NUM_LI; li++) begin : g_li
    for (genvar p = 0; p < NUM_PHYS; p++) begin : g_phys
      assign hit[li][p] = term_active(bus.map[li][2*p +: 2], bus.phys[p]);
      assign used[li][p] = term_assigned(bus.map[li][2*p +: 2]);
    end
    // An unmapped logical input takes its fixed default level.
    assign logical_d[li] = (|used[li]) ? (|hit[li]) : relay_pkg::LI_DEFAULTS[li];
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      logical_q <= relay_pkg::LI_DEFAULTS;
    end else begin
      logical_q <= logical_d;
    end
  end

  assign bus.logical = logical_q;

endmodule

//--- core/breaker_recloser_input_logic.sv
// Breaker position decode, recloser supervision, seal-ins and register slave.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module breaker_recloser_input_logic #(
  parameter int NUM_PHYS = 8,
  parameter int NUM_SEAL = 8,
  parameter int NUM_TARGET = 8,
  parameter int CNT_W = 32,
  parameter bit EARTH_FAULT_FITTED = 1'b1
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [relay_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [relay_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [relay_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic [NUM_PHYS-1:0] contact_i,
  input wire logic open_timer_start_i,
  input wire logic reset_timer_start_i,
  input wire logic remote_request_i,
  input wire logic panel_request_i,
  input wire logic [NUM_SEAL-1:0] alarm_cond_i,
  input wire logic [NUM_TARGET-1:0] target_cond_i,
  output logic [1:0] breaker_state_o,
  output logic breaker_unknown_o,
  output logic breaker_closed_logic_o,
  output logic breaker_open_logic_o,
  output logic auto_reclose_enable_o,
  output logic recloser_out_led_o,
  output logic earth_fault_permit_o,
  output logic open_timer_expired_o,
  output logic reset_timer_expired_o,
  output logic [CNT_W-1:0] open_timer_count_o,
  output logic remote_grant_o,
  output logic panel_grant_o,
  output logic [NUM_SEAL-1:0] sealed_o,
  output logic [NUM_TARGET-1:0] target_led_o,
  output logic irq_o
);

  localparam int NUM_LI = relay_pkg::NUM_LI;
  localparam int MAP_W = 2 * NUM_PHYS;
  localparam int IDX_W = $clog2(NUM_LI);
  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  input_map_if #(.NUM_PHYS(NUM_PHYS), .NUM_LI(NUM_LI)) map_bus ();

  input_mapper #(
    .NUM_PHYS(NUM_PHYS),
    .NUM_LI(NUM_LI)
  ) u_mapper (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .bus(map_bus.mapper)
  );

  logic [NUM_LI-1:0][MAP_W-1:0] map_q;
  logic [NUM_LI-1:0] li;

  assign map_bus.phys = contact_i;
  assign map_bus.map = map_q;
  assign li = map_bus.logical;

  // Register decode.
  function automatic logic addr_is(input logic [relay_pkg::ADDR_W-1:0] a,
                                   input logic [relay_pkg::ADDR_W-1:0] off);
    addr_is = (a == off);
  endfunction

  logic [relay_pkg::ADDR_W-1:0] map_off;
  logic map_sel;
  logic [IDX_W-1:0] map_idx;
  logic wr_ctrl;
  logic wr_mask;
  logic wr_open_lim;
  logic wr_reset_lim;
  logic rd_irq;

  assign map_off = reg_addr_i - relay_pkg::OFF_MAP_BASE;
  assign map_sel = (reg_addr_i >= relay_pkg::OFF_MAP_BASE) && (map_off[1:0] == 2'h0) &&
                   (int'(map_off[relay_pkg::ADDR_W-1:2]) < NUM_LI);
  assign map_idx = map_off[IDX_W+1:2];
  assign wr_ctrl = reg_we_i && addr_is(reg_addr_i, relay_pkg::OFF_CTRL);
  assign wr_mask = reg_we_i && addr_is(reg_addr_i, relay_pkg::OFF_IRQ_MASK);
  assign wr_open_lim = reg_we_i && addr_is(reg_addr_i, relay_pkg::OFF_OPEN_LIMIT);
  assign wr_reset_lim = reg_we_i && addr_is(reg_addr_i, relay_pkg::OFF_RESET_LIMIT);
  assign rd_irq = reg_re_i && addr_is(reg_addr_i, relay_pkg::OFF_IRQ_STATUS);

  logic manual_trip_q;
  logic [relay_pkg::IRQ_W-1:0] irq_mask_q;
  logic [CNT_W-1:0] open_limit_q;
  logic [CNT_W-1:0] reset_limit_q;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      manual_trip_q <= 1'b0;
      irq_mask_q <= '0;
      open_limit_q <= CNT_W'(relay_pkg::OPEN_LIMIT_RST);
      reset_limit_q <= CNT_W'(relay_pkg::RESET_LIMIT_RST);
    end else begin
      if (wr_ctrl) manual_trip_q <= reg_wdata_i[relay_pkg::CTRL_MANUAL_TRIP];
      if (wr_mask) irq_mask_q <= reg_wdata_i[relay_pkg::IRQ_W-1:0];
      if (wr_open_lim) open_limit_q <= CNT_W'(reg_wdata_i);
      if (wr_reset_lim) reset_limit_q <= CNT_W'(reg_wdata_i);
    end
  end

  // Map storage; reset leaves every pair deassigned so the defaults apply.
  for (genvar i = 0; i < NUM_LI; i++) begin : g_map
    always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
        map_q[i] <= '0;
      end else if (reg_we_i && map_sel && (map_idx == IDX_W'(i))) begin
        map_q[i] <= reg_wdata_i[MAP_W-1:0];
      end
    end
  end

  // Breaker position decode.
  logic aux_no;
  logic aux_nc;
  logic [1:0] brk_d;
  logic [1:0] brk_q;
  logic closed_logic_d;
  logic open_logic_d;

  assign aux_no = li[relay_pkg::LI_AUX_NO];
  assign aux_nc = li[relay_pkg::LI_AUX_NC];
  assign brk_d = (aux_no && !aux_nc) ? relay_pkg::BRK_CODE_CLOSED :
                 (!aux_no && aux_nc) ? relay_pkg::BRK_CODE_OPEN :
                 relay_pkg::BRK_CODE_UNKNOWN;
  // In manual-trip mode the normally-open contact alone gives the position.
  assign closed_logic_d = manual_trip_q ? aux_no : (brk_d == relay_pkg::BRK_CODE_CLOSED);
  assign open_logic_d = manual_trip_q ? !aux_no : (brk_d == relay_pkg::BRK_CODE_OPEN);

  logic closed_logic_q;
  logic open_logic_q;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      brk_q <= relay_pkg::BRK_CODE_UNKNOWN;
      closed_logic_q <= 1'b0;
      open_logic_q <= 1'b0;
    end else begin
      brk_q <= brk_d;
      closed_logic_q <= closed_logic_d;
      open_logic_q <= open_logic_d;
    end
  end

  logic ev_brk_change;
  logic ev_unknown;

  assign ev_brk_change = (brk_d != brk_q);
  assign ev_unknown = ev_brk_change && (brk_d == relay_pkg::BRK_CODE_UNKNOWN);

  // Recloser supervision and earth-fault permission.
  logic recl_en_q;
  logic earth_q;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      recl_en_q <= 1'b0;
      earth_q <= 1'b0;
    end else begin
      recl_en_q <= li[relay_pkg::LI_RECL_EN];
      earth_q <= EARTH_FAULT_FITTED && li[relay_pkg::LI_EARTH_EN];
    end
  end

  // Recloser open timer; the inhibit holds the count rather than clearing it.
  logic inhibit;
  relay_pkg::timer_state_t open_st_q;
  relay_pkg::timer_state_t open_st_d;
  logic [CNT_W-1:0] open_cnt_q;
  logic [CNT_W-1:0] open_cnt_d;
  logic open_exp_d;
  logic open_exp_q;
  logic [CNT_W-1:0] open_next;

  assign inhibit = li[relay_pkg::LI_INHIBIT];
  assign open_next = open_cnt_q + CNT_ONE;

  always_comb begin
    open_st_d = open_st_q;
    open_cnt_d = open_cnt_q;
    open_exp_d = 1'b0;
    if (open_timer_start_i) begin
      open_st_d = relay_pkg::TMR_RUN;
      open_cnt_d = CNT_ZERO;
    end else begin
      case (open_st_q)
        relay_pkg::TMR_IDLE: begin
          open_st_d = relay_pkg::TMR_IDLE;
        end
        relay_pkg::TMR_RUN: begin
          if (inhibit) begin
            open_st_d = relay_pkg::TMR_FROZEN;
          end else if (open_next >= open_limit_q) begin
            open_cnt_d = open_next;
            open_exp_d = 1'b1;
            open_st_d = relay_pkg::TMR_IDLE;
          end else begin
            open_cnt_d = open_next;
          end
        end
        relay_pkg::TMR_FROZEN: begin
          if (!inhibit) open_st_d = relay_pkg::TMR_RUN;
        end
        default: begin
          open_st_d = relay_pkg::TMR_IDLE;
        end
      endcase
    end
  end

  // Recloser reset timer; it never looks at the inhibit.
  relay_pkg::timer_state_t rst_st_q;
  relay_pkg::timer_state_t rst_st_d;
  logic [CNT_W-1:0] rst_cnt_q;
  logic [CNT_W-1:0] rst_cnt_d;
  logic rst_exp_d;
  logic rst_exp_q;
  logic [CNT_W-1:0] rst_next;

  assign rst_next = rst_cnt_q + CNT_ONE;

  always_comb begin
    rst_st_d = rst_st_q;
    rst_cnt_d = rst_cnt_q;
    rst_exp_d = 1'b0;
    if (reset_timer_start_i) begin
      rst_st_d = relay_pkg::TMR_RUN;
      rst_cnt_d = CNT_ZERO;
    end else begin
      case (rst_st_q)
        relay_pkg::TMR_RUN: begin
          rst_cnt_d = rst_next;
          if (rst_next >= reset_limit_q) begin
            rst_exp_d = 1'b1;
            rst_st_d = relay_pkg::TMR_IDLE;
          end
        end
        default: begin
          rst_st_d = relay_pkg::TMR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      open_st_q <= relay_pkg::TMR_IDLE;
      open_cnt_q <= CNT_ZERO;
      open_exp_q <= 1'b0;
      rst_st_q <= relay_pkg::TMR_IDLE;
      rst_cnt_q <= CNT_ZERO;
      rst_exp_q <= 1'b0;
    end else begin
      open_st_q <= open_st_d;
      open_cnt_q <= open_cnt_d;
      open_exp_q <= open_exp_d;
      rst_st_q <= rst_st_d;
      rst_cnt_q <= rst_cnt_d;
      rst_exp_q <= rst_exp_d;
    end
  end

  // Operation-record requests; only the remote path is gated by local mode.
  logic remote_grant_q;
  logic panel_grant_q;
  logic ev_refused;

  assign ev_refused = remote_request_i && li[relay_pkg::LI_LOCAL];

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      remote_grant_q <= 1'b0;
      panel_grant_q <= 1'b0;
    end else begin
      remote_grant_q <= remote_request_i && !li[relay_pkg::LI_LOCAL];
      panel_grant_q <= panel_request_i;
    end
  end

  // Seal-ins and targets; a present condition wins over any clear.
  logic seal_rst_prev_q;
  logic target_rst_prev_q;
  logic seal_clear;
  logic target_clear;
  logic [NUM_SEAL-1:0] sealed_q;
  logic [NUM_SEAL-1:0] sealed_d;
  logic [NUM_TARGET-1:0] target_q;
  logic [NUM_TARGET-1:0] target_d;
  logic ev_seal;

  assign seal_clear = (li[relay_pkg::LI_SEAL_RST] && !seal_rst_prev_q) ||
                      (wr_ctrl && reg_wdata_i[relay_pkg::CTRL_SEAL_CLEAR]);
  assign target_clear = (li[relay_pkg::LI_TARGET_RST] && !target_rst_prev_q) ||
                     (wr_ctrl && reg_wdata_i[relay_pkg::CTRL_TARGET_CLEAR]);
  assign sealed_d = alarm_cond_i | (sealed_q & {NUM_SEAL{!seal_clear}});
  assign target_d = target_cond_i | (target_q & {NUM_TARGET{!target_clear}});
  assign ev_seal = |(alarm_cond_i & ~sealed_q);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      seal_rst_prev_q <= 1'b1;
      target_rst_prev_q <= 1'b1;
      sealed_q <= '0;
      target_q <= '0;
    end else begin
      seal_rst_prev_q <= li[relay_pkg::LI_SEAL_RST];
      target_rst_prev_q <= li[relay_pkg::LI_TARGET_RST];
      sealed_q <= sealed_d;
      target_q <= target_d;
    end
  end

  // Interrupt status; a read clears it, but an event in the same cycle stays.
  logic [relay_pkg::IRQ_W-1:0] irq_ev;
  logic [relay_pkg::IRQ_W-1:0] irq_st_q;
  logic [relay_pkg::IRQ_W-1:0] irq_st_d;

  assign irq_ev[relay_pkg::IRQ_BRK_CHANGE] = ev_brk_change;
  assign irq_ev[relay_pkg::IRQ_UNKNOWN] = ev_unknown;
  assign irq_ev[relay_pkg::IRQ_REFUSED] = ev_refused;
  assign irq_ev[relay_pkg::IRQ_OPEN_EXP] = open_exp_d;
  assign irq_ev[relay_pkg::IRQ_RESET_EXP] = rst_exp_d;
  assign irq_ev[relay_pkg::IRQ_SEAL] = ev_seal;
  assign irq_st_d = irq_ev | (irq_st_q & {relay_pkg::IRQ_W{!rd_irq}});

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= irq_st_d;
    end
  end

  // Read path; data stand only in the cycle after the strobe.
  logic [relay_pkg::DATA_W-1:0] state_word;
  logic [relay_pkg::DATA_W-1:0] rd_value;
  logic [relay_pkg::DATA_W-1:0] rdata_q;

  assign state_word = relay_pkg::DATA_W'({li, 3'h0, (rst_st_q == relay_pkg::TMR_RUN),
                      (open_st_q != relay_pkg::TMR_IDLE),
                      (brk_q == relay_pkg::BRK_CODE_UNKNOWN), brk_q});
  assign rd_value =
    addr_is(reg_addr_i, relay_pkg::OFF_CTRL) ? relay_pkg::DATA_W'(manual_trip_q) :
    addr_is(reg_addr_i, relay_pkg::OFF_STATE) ? state_word :
    addr_is(reg_addr_i, relay_pkg::OFF_IRQ_STATUS) ? relay_pkg::DATA_W'(irq_st_q) :
    addr_is(reg_addr_i, relay_pkg::OFF_IRQ_MASK) ? relay_pkg::DATA_W'(irq_mask_q) :
    addr_is(reg_addr_i, relay_pkg::OFF_OPEN_LIMIT) ? relay_pkg::DATA_W'(open_limit_q) :
    addr_is(reg_addr_i, relay_pkg::OFF_RESET_LIMIT) ? relay_pkg::DATA_W'(reset_limit_q) :
    addr_is(reg_addr_i, relay_pkg::OFF_OPEN_COUNT) ? relay_pkg::DATA_W'(open_cnt_q) :
    addr_is(reg_addr_i, relay_pkg::OFF_SEALED) ? relay_pkg::DATA_W'(sealed_q) :
    addr_is(reg_addr_i, relay_pkg::OFF_TARGETS) ? relay_pkg::DATA_W'(target_q) :
    map_sel ? relay_pkg::DATA_W'(map_q[map_idx]) :
    '0;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_re_i ? rd_value : '0;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign breaker_state_o = brk_q;
  assign breaker_unknown_o = (brk_q == relay_pkg::BRK_CODE_UNKNOWN);
  assign breaker_closed_logic_o = closed_logic_q;
  assign breaker_open_logic_o = open_logic_q;
  assign auto_reclose_enable_o = recl_en_q;
  assign recloser_out_led_o = !recl_en_q;
  assign earth_fault_permit_o = earth_q;
  assign open_timer_expired_o = open_exp_q;
  assign reset_timer_expired_o = rst_exp_q;
  assign open_timer_count_o = open_cnt_q;
  assign remote_grant_o = remote_grant_q;
  assign panel_grant_o = panel_grant_q;
  assign sealed_o = sealed_q;
  assign target_led_o = target_q;
  assign irq_o = |(irq_st_q & irq_mask_q);

endmodule

//--- sim/breaker_recloser_input_logic_asserts.sv
// Port-level checker for the breaker and recloser input supervision block.
`timescale 1ns/10ps
module breaker_recloser_input_logic_asserts #(
  parameter int CNT_W = 32,
  parameter int NUM_SEAL = 8,
  parameter int NUM_TARGET = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic open_timer_start_i,
  input wire logic reset_timer_start_i,
  input wire logic remote_request_i,
  input wire logic panel_request_i,
  input wire logic [NUM_SEAL-1:0] alarm_cond_i,
  input wire logic [NUM_TARGET-1:0] target_cond_i,
  input wire logic [1:0] breaker_state_o,
  input wire logic breaker_unknown_o,
  input wire logic breaker_closed_logic_o,
  input wire logic breaker_open_logic_o,
  input wire logic auto_reclose_enable_o,
  input wire logic recloser_out_led_o,
  input wire logic open_timer_expired_o,
  input wire logic reset_timer_expired_o,
  input wire logic [CNT_W-1:0] open_timer_count_o,
  input wire logic remote_grant_o,
  input wire logic panel_grant_o,
  input wire logic [NUM_SEAL-1:0] sealed_o,
  input wire logic [NUM_TARGET-1:0] target_led_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_led; recloser_out_led_o == !auto_reclose_enable_o; endproperty
  a_led: assert property (p_led) else $error("recloser out lamp wrong");
  property p_unk; breaker_unknown_o == (breaker_state_o == 2'h0); endproperty
  a_unk: assert property (p_unk) else $error("unknown flag disagrees with state");
  property p_code; breaker_state_o != 2'h3; endproperty
  a_code: assert property (p_code) else $error("illegal breaker code");
  property p_excl; !(breaker_closed_logic_o && breaker_open_logic_o); endproperty
  a_excl: assert property (p_excl) else $error("closed and open both set");
  property p_panel; panel_request_i |=> panel_grant_o; endproperty
  a_panel: assert property (p_panel) else $error("panel request not granted");
  property p_remote; remote_grant_o |-> $past(remote_request_i); endproperty
  a_remote: assert property (p_remote) else $error("grant without request");
  property p_seal; |alarm_cond_i |=> ((sealed_o & $past(alarm_cond_i)) == $past(alarm_cond_i));
  endproperty
  a_seal: assert property (p_seal) else $error("alarm not sealed in");
  property p_target;
    |target_cond_i |=> ((target_led_o & $past(target_cond_i)) == $past(target_cond_i));
  endproperty
  a_target: assert property (p_target) else $error("target not latched");
  property p_step; !open_timer_start_i |=> (open_timer_count_o == $past(open_timer_count_o))
    || (open_timer_count_o == $past(open_timer_count_o) + 1'b1); endproperty
  a_step: assert property (p_step) else $error("open count jumped");
  property p_start; open_timer_start_i |=> open_timer_count_o <= 1; endproperty
  a_start: assert property (p_start) else $error("open timer did not restart");
  property p_opulse; open_timer_expired_o && !open_timer_start_i |=> !open_timer_expired_o;
  endproperty
  a_opulse: assert property (p_opulse) else $error("open expiry too long");
  property p_rpulse; reset_timer_expired_o && !reset_timer_start_i |=> !reset_timer_expired_o;
  endproperty
  a_rpulse: assert property (p_rpulse) else $error("reset expiry too long");
endmodule

bind breaker_recloser_input_logic breaker_recloser_input_logic_asserts #(
  .CNT_W(CNT_W), .NUM_SEAL(NUM_SEAL), .NUM_TARGET(NUM_TARGET)
) breaker_recloser_input_logic_asserts_inst (
  .clk_i(clk_i), .resetn_i(resetn_i), .open_timer_start_i(open_timer_start_i),
  .reset_timer_start_i(reset_timer_start_i), .remote_request_i(remote_request_i),
  .panel_request_i(panel_request_i), .alarm_cond_i(alarm_cond_i),
  .target_cond_i(target_cond_i), .breaker_state_o(breaker_state_o),
  .breaker_unknown_o(breaker_unknown_o), .breaker_closed_logic_o(breaker_closed_logic_o),
  .breaker_open_logic_o(breaker_open_logic_o), .auto_reclose_enable_o(auto_reclose_enable_o),
  .recloser_out_led_o(recloser_out_led_o), .open_timer_expired_o(open_timer_expired_o),
  .reset_timer_expired_o(reset_timer_expired_o), .open_timer_count_o(open_timer_count_o),
  .remote_grant_o(remote_grant_o), .panel_grant_o(panel_grant_o), .sealed_o(sealed_o),
  .target_led_o(target_led_o)
);

//--- sim/breaker_contacts_model.sv
// Breaker auxiliary contacts and control switches wired to the contact inputs.
`timescale 1ns/10ps
module breaker_contacts_model (
  input wire logic clk_i,
  input wire logic [1:0] pos_i,
  input wire logic [5:0] switch_i,
  output logic [7:0] contact_o
);
  // Position 1 is closed, 2 open, 0 mid travel with both auxiliaries open, 3 a welded pair.
  // Contacts follow one clock late, since a mechanism never answers in the same instant.
  always_ff @(posedge clk_i) begin
    contact_o[0] <= pos_i[0];
    contact_o[1] <= pos_i[1];
    contact_o[7:2] <= switch_i;
  end
endmodule

//--- sim/breaker_recloser_input_logic_tb_top.sv
// Self-checking bench for the breaker and recloser input supervision block.
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module breaker_recloser_input_logic_tb_top;
  logic clk;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic ots = 1'b0;
  logic rts = 1'b0;
  logic rreq = 1'b0;
  logic preq = 1'b0;
  logic [7:0] alarm = 8'h00;
  logic [7:0] tcond = 8'h00;
  logic [1:0] pos = 2'h1;
  logic [5:0] sw = 6'h02;
  logic [7:0] contact;
  logic [31:0] rdata;
  logic [1:0] bst;
  logic unk, cl, op, are, led, efp, oexp, rexp, rgr, pgr, irq;
  logic [31:0] cnt;
  logic [7:0] sealed, tled;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;

  breaker_contacts_model breaker_contacts_model_inst (.clk_i(clk), .pos_i(pos),
    .switch_i(sw), .contact_o(contact));
  breaker_recloser_input_logic breaker_recloser_input_logic_inst (.clk_i(clk),
    .resetn_i(resetn), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .contact_i(contact), .open_timer_start_i(ots),
    .reset_timer_start_i(rts), .remote_request_i(rreq), .panel_request_i(preq),
    .alarm_cond_i(alarm), .target_cond_i(tcond), .breaker_state_o(bst), .breaker_unknown_o(unk),
    .breaker_closed_logic_o(cl), .breaker_open_logic_o(op), .auto_reclose_enable_o(are),
    .recloser_out_led_o(led), .earth_fault_permit_o(efp), .open_timer_expired_o(oexp),
    .reset_timer_expired_o(rexp), .open_timer_count_o(cnt), .remote_grant_o(rgr),
    .panel_grant_o(pgr), .sealed_o(sealed), .target_led_o(tled), .irq_o(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // The run should need about 170 cycles; the ceiling leaves ample slack.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      test_done();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    `CHK(rdata & m, e)
  endtask

  task automatic t_defaults();
    tick(3);
    `CHK(unk, 1'b1)
    `CHK(are, 1'b1)
    `CHK(efp, 1'b1)
    rdc(relay_pkg::OFF_STATE, 32'h0000_FF00, 32'h0000_1800);
    rdc(relay_pkg::OFF_OPEN_LIMIT, 32'hFFFF_FFFF, 32'h0000_03E8);
    rdc(8'h3C, 32'hFFFF_FFFF, 32'h0);
  endtask

  task automatic t_breaker();
    logic [31:0] mapv [8] = '{32'h10, 32'h1, 32'h4, 32'h40, 32'h200, 32'h400, 32'h1000, 32'h4000};
    logic [1:0] pv [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
    logic [1:0] ev [4] = '{relay_pkg::BRK_CODE_CLOSED, relay_pkg::BRK_CODE_OPEN,
      relay_pkg::BRK_CODE_UNKNOWN, relay_pkg::BRK_CODE_UNKNOWN};
    for (int i = 0; i < 8; i++) begin
      wr(relay_pkg::OFF_MAP_BASE + 8'(4 * i), mapv[i]);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      pos <= pv[i];
      tick(5);
      `CHK(bst, ev[i])
      `CHK(cl, i == 0)
      `CHK(op, i == 1)
    end
    wr(relay_pkg::OFF_CTRL, 32'h1);
    tick(3);
    `CHK(cl, 1'b1)
    `CHK(op, 1'b0)
    wr(relay_pkg::OFF_CTRL, 32'h0);
  endtask

  task automatic t_enables();
    @(posedge clk);
    sw <= 6'h04;
    tick(5);
    `CHK(are, 1'b0)
    `CHK(led, 1'b1)
    `CHK(efp, 1'b0)
    @(posedge clk);
    sw <= 6'h02;
    tick(5);
    `CHK(led, 1'b0)
  endtask

  task automatic t_timers();
    logic [31:0] f;
    int n;
    wr(relay_pkg::OFF_OPEN_LIMIT, 32'h3);
    @(posedge clk);
    ots <= 1'b1;
    @(posedge clk);
    ots <= 1'b0;
    tick(3);
    `CHK(oexp, 1'b1)
    `CHK(cnt, 32'h3)
    wr(relay_pkg::OFF_OPEN_LIMIT, 32'h14);
    wr(relay_pkg::OFF_RESET_LIMIT, 32'h0C);
    @(posedge clk);
    ots <= 1'b1;
    rts <= 1'b1;
    @(posedge clk);
    ots <= 1'b0;
    rts <= 1'b0;
    repeat (5) @(posedge clk);
    sw <= 6'h03;
    tick(7);
    `CHK(rexp, 1'b1)
    f = cnt;
    tick(4);
    `CHK(cnt, f)
    @(posedge clk);
    sw <= 6'h02;
    n = 0;
    #1;
    while (oexp !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    // A restart from zero would need the full twenty cycles after release.
    `CHK(n <= 24 - int'(f), 1'b1)
    `CHK(cnt, 32'h14)
  endtask

  task automatic t_requests();
    wr(relay_pkg::OFF_IRQ_MASK, 32'h4);
    // Earlier scenarios left breaker change, unknown entry and both timer expiries pending.
    rdc(relay_pkg::OFF_IRQ_STATUS, 32'h3F, 32'h1B);
    for (int lm = 1; lm >= 0; lm--) begin
      @(posedge clk);
      sw <= {2'b00, lm[0], 3'b010};
      tick(4);
      @(posedge clk);
      preq <= 1'b1;
      @(posedge clk);
      preq <= 1'b0;
      rreq <= 1'b1;
      #1;
      `CHK(pgr, 1'b1)
      @(posedge clk);
      rreq <= 1'b0;
      #1;
      `CHK(rgr, !lm[0])
      `CHK(irq, lm[0])
      rdc(relay_pkg::OFF_IRQ_STATUS, 32'h4, {29'h0, lm[0], 2'h0});
      tick(1);
      `CHK(irq, 1'b0)
    end
  endtask

  task automatic t_sealin();
    @(posedge clk);
    alarm <= 8'h81;
    tcond <= 8'h03;
    @(posedge clk);
    alarm <= 8'h00;
    tcond <= 8'h00;
    tick(3);
    `CHK(sealed, 8'h81)
    `CHK(tled, 8'h03)
    @(posedge clk);
    sw <= 6'h12;
    tick(5);
    `CHK(sealed, 8'h00)
    `CHK(tled, 8'h03)
    @(posedge clk);
    alarm <= 8'h04;
    sw <= 6'h32;
    @(posedge clk);
    alarm <= 8'h00;
    tick(5);
    `CHK(sealed, 8'h04)
    `CHK(tled, 8'h00)
    wr(relay_pkg::OFF_CTRL, 32'h2);
    #1;
    `CHK(sealed, 8'h00)
  endtask

  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_defaults();
    t_breaker();
    t_enables();
    t_timers();
    t_requests();
    t_sealin();
    test_done();
  end
endmodule
